// File: rtl/sound_gen_pkg.sv
// constants for the sound generator clock block: register indices,
// field positions, reset values and divider ratios.
// assumes a 100 MHz system clock and oscillator levels synchronous to it.
package sound_gen_pkg;
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int IDX_W      = 10;
    localparam int NIB_W      = 4;
    localparam int SLOT_W     = 4;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CH1_LOW   = 10'h360;
    localparam logic [IDX_W-1:0] IDX_CH1_HIGH  = 10'h361;
    localparam logic [IDX_W-1:0] IDX_CH2_NIB1  = 10'h362;
    localparam logic [IDX_W-1:0] IDX_CH2_NIB2  = 10'h363;
    localparam logic [IDX_W-1:0] IDX_CH2_NIB3  = 10'h364;
    localparam logic [IDX_W-1:0] IDX_CH2_NIB4  = 10'h365;
    localparam logic [IDX_W-1:0] IDX_CH_ENABLE = 10'h366;
    localparam logic [IDX_W-1:0] IDX_PRESCALER = 10'h367;
    localparam logic [IDX_W-1:0] IDX_CLK_SEL   = 10'h368;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h369;
    localparam int               REG_COUNT     = 9;

    // field positions
    localparam int PRE_CH1_LSB   = 0;
    localparam int PRE_CH2_LSB   = 2;
    localparam int PRE_FIELD_W   = 2;
    localparam int SEL_SRC_BIT   = 0;
    localparam int SEL_ALARM_BIT = 1;
    localparam int SEL_RATE_BIT  = 2;
    localparam int MODE_BIT      = 3;
    localparam int STAT_CH1_BIT  = 0;
    localparam int STAT_CH2_BIT  = 1;
    localparam int STAT_BASE_BIT = 2;
    localparam int STAT_SRC_BIT  = 3;

    localparam logic [NIB_W-1:0] NIB_RST = 4'h0;

    // base clock normalisation, frequencies in kHz
    localparam int BASE_KHZ    = 32;
    localparam int RC_FAST_KHZ = 500;
    localparam int RC_SLOW_KHZ = 262;
    localparam int DIV_CNT_W   = 5;
    localparam int DIV_FAST    = (RC_FAST_KHZ + BASE_KHZ / 2) / BASE_KHZ;
    localparam int DIV_SLOW    = (RC_SLOW_KHZ + BASE_KHZ / 2) / BASE_KHZ;

    // shift counters
    localparam int               CHAN_COUNT = 2;
    localparam int               TONE_W     = 7;
    localparam int               CH1_W      = 7;
    localparam int               CH2_W      = 15;
    localparam int               PRE_CNT_W  = 3;
    localparam logic [TONE_W-1:0] TONE_END  = 7'h01;
endpackage

// File: rtl/sound_rate_divider.sv
// per-channel prescaler: turns the base tick into a working tick.
// assumes base_tick is a one-cycle strobe in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module sound_rate_divider (
    input  wire logic                                 clk,       // system clock
    input  wire logic                                 nrst,      // sync reset, low
    input  wire logic                                 base_tick, // 32 kHz strobe
    input  wire logic [sound_gen_pkg::PRE_FIELD_W-1:0] rate_sel, // 0:/1 1:/2 2:/4 3:/8
    output logic                                      work_tick  // working strobe
);
    import sound_gen_pkg::*;

    logic [PRE_CNT_W-1:0] phase_ff;
    logic [PRE_CNT_W-1:0] nxt_phase;
    logic [PRE_CNT_W-1:0] phase_mask;
    logic                 fire;
    logic                 work_tick_ff;

    // mask of low phase bits; all zero means every base tick passes
    assign phase_mask = (3'h1 << rate_sel) - 3'h1;
    assign fire       = base_tick && ((phase_ff & phase_mask) == '0);
    assign nxt_phase  = base_tick ? phase_ff + 3'h1 : phase_ff;
    assign work_tick  = work_tick_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_ff     <= '0;
            work_tick_ff <= 1'b0;
        end else begin
            phase_ff     <= nxt_phase;
            work_tick_ff <= fire;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sound_shift_channel.sv
// one sound channel: 7-bit tone counter and full-width noise counter.
// assumes restart is a one-cycle strobe after a write of the seed.
`timescale 1ns/1ns
`default_nettype none
module sound_shift_channel #(
    parameter int CHAN_W = 7
) (
    input  wire logic              clk,        // system clock
    input  wire logic              nrst,       // sync reset, low
    input  wire logic              work_tick,  // working clock strobe
    input  wire logic              noise_mode, // 1 noise, 0 tone
    input  wire logic              restart,    // reload seed strobe
    input  wire logic [CHAN_W-1:0] init_value, // seed
    output logic                   chan_out    // sound output level
);
    import sound_gen_pkg::*;

    logic [TONE_W-1:0] tone_ff;
    logic [CHAN_W-1:0] noise_ff;
    logic              out_ff;
    logic [TONE_W-1:0] tone_seed;
    logic [TONE_W-1:0] tone_step;
    logic              tone_wrap;
    logic [CHAN_W-1:0] noise_step;
    logic              noise_fb;
    logic [TONE_W-1:0] nxt_tone;
    logic [CHAN_W-1:0] nxt_noise;
    logic              nxt_out;

    // tone uses the top seven seed bits on the wide channel
    assign tone_seed  = init_value[CHAN_W-1 -: TONE_W];
    assign tone_step  = {tone_ff[TONE_W-2:0], tone_ff[TONE_W-1] ^ tone_ff[TONE_W-2]};
    assign tone_wrap  = (tone_step == TONE_END);
    // an all-zero noise state would lock up, so feed a one in
    assign noise_fb   = (noise_ff == '0) | (noise_ff[CHAN_W-1] ^ noise_ff[CHAN_W-2]);
    assign noise_step = {noise_ff[CHAN_W-2:0], noise_fb};

    assign nxt_tone  = restart ? tone_seed :
                       (work_tick && !noise_mode) ?
                       (tone_wrap ? tone_seed : tone_step) : tone_ff;
    assign nxt_noise = restart ? init_value :
                       (work_tick && noise_mode) ? noise_step : noise_ff;
    assign nxt_out   = (!work_tick || restart) ? out_ff :
                       noise_mode ? noise_step[CHAN_W-1] :
                       (tone_wrap ? ~out_ff : out_ff);
    assign chan_out  = out_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tone_ff  <= '0;
            noise_ff <= '0;
            out_ff   <= 1'b0;
        end else begin
            tone_ff  <= nxt_tone;
            noise_ff <= nxt_noise;
            out_ff   <= nxt_out;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sound_gen_clock_prescaler.sv
// top of the sound generator clock block: apb register file, base clock
// normalisation from either oscillator, and two prescaled channels.
// assumes both oscillator levels are synchronous to clk and much slower.
//
// Summary of operation
// - prescaler register bits 1-0 serve channel one, bits 3-2 channel two.
// - prescaler field 00,01,10,11 divides base clock by 1,2,4,8.
// - source bit 0 picks low oscillator when clear, high oscillator when set.
// - rate bit zero means 500k high oscillator, one means 262k.
// - base clock is 32 kHz whatever source and rate are chosen.
// - tone output toggles every N working ticks, frequency clock over 2N.
// - tone count length is at most 127 working ticks.
// - seven-bit seed maps to count length, seed 20h gives 122.
// - bit 1 of source register switches alarm; both registers write-only.
// - channel one uses a 7-bit shift counter, channel two 15-bit.
// - mode bit one gives noise, zero gives tone.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module sound_gen_clock_prescaler (
    input  wire logic                             clk,               // system clock
    input  wire logic                             nrst,              // sync reset, low
    input  wire logic                             psel,              // apb select
    input  wire logic                             penable,           // apb enable
    input  wire logic                             pwrite,            // apb direction
    input  wire logic [sound_gen_pkg::ADDR_W-1:0] paddr,             // apb byte address
    input  wire logic [sound_gen_pkg::DATA_W-1:0] pwdata,            // apb write data
    input  wire logic [3:0]                       pstrb,             // apb byte strobes
    output logic      [sound_gen_pkg::DATA_W-1:0] prdata,            // apb read data
    output logic                                  pready,            // apb ready
    output logic                                  pslverr,           // apb error
    input  wire logic                             low_speed_source,  // low osc level
    input  wire logic                             high_speed_source, // high osc level
    output logic                                  base_clock_tick,   // 32 kHz strobe
    output logic      [1:0]                       tone_working_clock,// per-channel strobes
    output logic                                  chan1_out,         // channel one sound
    output logic                                  chan2_out,         // channel two sound
    output logic                                  alarm_switch       // alarm on level
);
    import sound_gen_pkg::*;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [IDX_W-1:0]  acc_idx;
    logic [SLOT_W-1:0] acc_slot;
    logic              aligned;
    logic              in_wo;
    logic              is_status;
    logic              mapped;
    logic              setup_ph;
    logic              access_ph;
    logic              wr_fire;
    logic              bad_access;

    assign acc_idx    = paddr[ADDR_W-1:2];
    assign acc_slot   = SLOT_W'(acc_idx - IDX_CH1_LOW);
    assign aligned    = (paddr[1:0] == 2'h0);
    assign in_wo      = aligned && (acc_idx >= IDX_CH1_LOW) && (acc_idx <= IDX_CLK_SEL);
    assign is_status  = aligned && (acc_idx == IDX_STATUS);
    assign mapped     = in_wo || is_status;
    assign setup_ph   = psel && !penable;
    assign access_ph  = psel && penable;
    // a write without the low byte lane carries no nibble and is dropped
    assign wr_fire    = access_ph && pwrite && in_wo && pstrb[0];
    // status cannot be written; unmapped or misaligned words are refused
    assign bad_access = !mapped || (pwrite && is_status);
    assign pready     = 1'b1;
    assign pslverr    = access_ph && bad_access;

    // ------------------------------------------------------------------
    // write-only register file
    // ------------------------------------------------------------------
    logic [NIB_W-1:0] reg_ff [REG_COUNT];

    genvar gr;
    generate
        for (gr = 0; gr < REG_COUNT; gr++) begin : g_reg
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    reg_ff[gr] <= NIB_RST;
                end else if (wr_fire && (acc_slot == SLOT_W'(gr))) begin
                    reg_ff[gr] <= pwdata[NIB_W-1:0];
                end
            end
        end
    endgenerate

    localparam int SL_CH1_LOW  = int'(IDX_CH1_LOW - IDX_CH1_LOW);
    localparam int SL_CH1_HIGH = int'(IDX_CH1_HIGH - IDX_CH1_LOW);
    localparam int SL_CH2_NIB1 = int'(IDX_CH2_NIB1 - IDX_CH1_LOW);
    localparam int SL_CH2_NIB2 = int'(IDX_CH2_NIB2 - IDX_CH1_LOW);
    localparam int SL_CH2_NIB3 = int'(IDX_CH2_NIB3 - IDX_CH1_LOW);
    localparam int SL_CH2_NIB4 = int'(IDX_CH2_NIB4 - IDX_CH1_LOW);
    localparam int SL_PRESCALE = int'(IDX_PRESCALER - IDX_CH1_LOW);
    localparam int SL_CLK_SEL  = int'(IDX_CLK_SEL - IDX_CH1_LOW);

    logic src_high;
    logic rc_rate_pick;
    logic chan1_noise_mode;
    logic chan2_noise_mode;
    logic [PRE_FIELD_W-1:0] chan_div [CHAN_COUNT];

    assign src_high         = reg_ff[SL_CLK_SEL][SEL_SRC_BIT];
    assign rc_rate_pick     = reg_ff[SL_CLK_SEL][SEL_RATE_BIT];
    assign alarm_switch     = reg_ff[SL_CLK_SEL][SEL_ALARM_BIT];
    assign chan1_noise_mode = reg_ff[SL_CH1_HIGH][MODE_BIT];
    assign chan2_noise_mode = reg_ff[SL_CH2_NIB4][MODE_BIT];
    assign chan_div[0] = reg_ff[SL_PRESCALE][PRE_CH1_LSB +: PRE_FIELD_W];
    assign chan_div[1] = reg_ff[SL_PRESCALE][PRE_CH2_LSB +: PRE_FIELD_W];

    // ------------------------------------------------------------------
    // base clock normalisation
    // ------------------------------------------------------------------
    localparam logic [DIV_CNT_W-1:0] FAST_END = DIV_CNT_W'(DIV_FAST - 1);
    localparam logic [DIV_CNT_W-1:0] SLOW_END = DIV_CNT_W'(DIV_SLOW - 1);

    logic                 low_prev_ff;
    logic                 high_prev_ff;
    logic [DIV_CNT_W-1:0] hs_cnt_ff;
    logic [DIV_CNT_W-1:0] nxt_hs_cnt;
    logic [DIV_CNT_W-1:0] hs_end;
    logic                 low_rise;
    logic                 high_rise;
    logic                 hs_wrap;
    logic                 base_tick;
    logic                 base_tick_ff;
    logic                 base_phase_ff;

    assign low_rise   = low_speed_source && !low_prev_ff;
    assign high_rise  = high_speed_source && !high_prev_ff;
    // the rate bit is trusted; a wrong setting gives a wrong base rate
    assign hs_end     = rc_rate_pick ? SLOW_END : FAST_END;
    assign hs_wrap    = high_rise && (hs_cnt_ff >= hs_end);
    // counter is held clear while the low source is in use
    assign nxt_hs_cnt = !src_high ? '0 :
                        !high_rise ? hs_cnt_ff :
                        hs_wrap ? '0 : hs_cnt_ff + 5'h01;
    assign base_tick  = src_high ? hs_wrap : low_rise;
    assign base_clock_tick = base_tick_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            low_prev_ff   <= low_speed_source;
            high_prev_ff  <= high_speed_source;
            hs_cnt_ff     <= '0;
            base_tick_ff  <= 1'b0;
            base_phase_ff <= 1'b0;
        end else begin
            low_prev_ff   <= low_speed_source;
            high_prev_ff  <= high_speed_source;
            hs_cnt_ff     <= nxt_hs_cnt;
            base_tick_ff  <= base_tick;
            base_phase_ff <= base_phase_ff ^ base_tick;
        end
    end

    // ------------------------------------------------------------------
    // channel seeds and restart strobes
    // ------------------------------------------------------------------
    logic [CH2_W-1:0] chan_seed [CHAN_COUNT];
    logic [CHAN_COUNT-1:0] chan_mode;
    logic [CHAN_COUNT-1:0] restart_ff;
    logic [CHAN_COUNT-1:0] nxt_restart;
    logic [CHAN_COUNT-1:0] chan_level;
    logic ch1_hit;
    logic ch2_hit;

    assign chan_seed[0] = {8'h00, reg_ff[SL_CH1_HIGH][2:0], reg_ff[SL_CH1_LOW]};
    assign chan_seed[1] = {reg_ff[SL_CH2_NIB4][2:0], reg_ff[SL_CH2_NIB3],
                           reg_ff[SL_CH2_NIB2], reg_ff[SL_CH2_NIB1]};
    assign chan_mode    = {chan2_noise_mode, chan1_noise_mode};
    assign ch1_hit = (acc_slot == SLOT_W'(SL_CH1_LOW)) ||
                     (acc_slot == SLOT_W'(SL_CH1_HIGH));
    assign ch2_hit = (acc_slot >= SLOT_W'(SL_CH2_NIB1)) &&
                     (acc_slot <= SLOT_W'(SL_CH2_NIB4));
    // restart a cycle after the write so the new seed is already stored
    assign nxt_restart = {wr_fire && ch2_hit, wr_fire && ch1_hit};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            restart_ff <= '0;
        end else begin
            restart_ff <= nxt_restart;
        end
    end

    // ------------------------------------------------------------------
    // per-channel prescaler and shift counter
    // ------------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < CHAN_COUNT; gc++) begin : g_chan
            localparam int CW = (gc == 0) ? CH1_W : CH2_W;
            logic work_tick;

            sound_rate_divider u_div (
                .clk       (clk),
                .nrst      (nrst),
                .base_tick (base_tick),
                .rate_sel  (chan_div[gc]),
                .work_tick (work_tick)
            );

            sound_shift_channel #(
                .CHAN_W (CW)
            ) u_chan (
                .clk        (clk),
                .nrst       (nrst),
                .work_tick  (work_tick),
                .noise_mode (chan_mode[gc]),
                .restart    (restart_ff[gc]),
                .init_value (chan_seed[gc][CW-1:0]),
                .chan_out   (chan_level[gc])
            );

            assign tone_working_clock[gc] = work_tick;
        end
    endgenerate

    assign chan1_out = chan_level[0];
    assign chan2_out = chan_level[1];

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [NIB_W-1:0]  status_nib;
    logic [DATA_W-1:0] prdata_ff;
    logic [DATA_W-1:0] nxt_prdata;

    assign status_nib = {src_high, base_phase_ff, chan_level[1], chan_level[0]};
    // write-only words read as zero; data is latched in the setup cycle
    assign nxt_prdata = !setup_ph ? prdata_ff :
                        (is_status && !pwrite) ?
                        {{(DATA_W - NIB_W){1'b0}}, status_nib} : '0;
    assign prdata = prdata_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata_ff <= '0;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end
endmodule
`default_nettype wire

// File: test/sound_gen_chk.sv
// checker for the sound generator clock block, bound to its top module.
// assumes only the top module's ports are visible; tracks the source bit itself.
`timescale 1ns/1ns
`default_nettype none
module sound_gen_chk (
    input wire logic                             clk,                // system clock
    input wire logic                             nrst,               // sync reset, low
    input wire logic                             psel,               // apb select
    input wire logic                             penable,            // apb enable
    input wire logic                             pwrite,             // apb direction
    input wire logic [sound_gen_pkg::ADDR_W-1:0] paddr,              // apb address
    input wire logic [sound_gen_pkg::DATA_W-1:0] pwdata,             // apb write data
    input wire logic [3:0]                       pstrb,              // apb strobes
    input wire logic [sound_gen_pkg::DATA_W-1:0] prdata,             // apb read data
    input wire logic                             pready,             // apb ready
    input wire logic                             pslverr,            // apb error
    input wire logic                             low_speed_source,   // low osc level
    input wire logic [1:0]                       tone_working_clock, // working strobes
    input wire logic                             base_clock_tick,    // base strobe
    input wire logic                             alarm_switch        // alarm level
);
    import sound_gen_pkg::*;
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    wire logic       acc    = psel && penable;
    wire logic [9:0] idx    = paddr[11:2];
    wire logic       sel_wr = acc && pwrite && pstrb[0] && paddr == {IDX_CLK_SEL, 2'b00};
    logic            src_ff;
    logic [2:0]      settle_ff;
    // a source switch may swallow one edge, so edges are judged once settled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            src_ff    <= 1'b0;
            settle_ff <= 3'd0;
        end else if (sel_wr) begin
            src_ff    <= pwdata[0];
            settle_ff <= 3'd0;
        end else if (settle_ff != 3'd7) begin
            settle_ff <= settle_ff + 3'd1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    zero_wait_a: assert property (acc |-> pready)
        else $error("access phase without ready");
    misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    unmapped_err_a: assert property (acc && (idx < IDX_CH1_LOW || idx > IDX_STATUS) |-> pslverr)
        else $error("unmapped access not refused");
    status_wr_a: assert property (acc && pwrite && paddr == {IDX_STATUS, 2'b00} |-> pslverr)
        else $error("status write not refused");
    wo_read_a: assert property (
        acc && !pwrite && paddr[1:0] == 2'b00 && idx >= IDX_CH1_LOW && idx <= IDX_CLK_SEL
        |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("write-only register read back data");
    alarm_follow_a: assert property (sel_wr |=> alarm_switch == $past(pwdata[1]))
        else $error("alarm level does not follow written bit");
    base_pulse_a: assert property (base_clock_tick |=> !base_clock_tick)
        else $error("base strobe longer than one cycle");
    work_base_a: assert property (
        tone_working_clock != 2'b00 |-> base_clock_tick || $past(base_clock_tick))
        else $error("working strobe without base strobe");
    low_src_a: assert property (
        settle_ff == 3'd7 && !src_ff && $rose(low_speed_source) |-> ##[1:4] base_clock_tick)
        else $error("low oscillator edge gave no base strobe");
    base_cov: cover property (base_clock_tick);
    work_cov: cover property (tone_working_clock[1]);
    alarm_cov: cover property ($rose(alarm_switch));
    err_cov: cover property (acc && pslverr);
endmodule

bind sound_gen_clock_prescaler sound_gen_chk chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_source(low_speed_source),
    .tone_working_clock(tone_working_clock), .base_clock_tick(base_clock_tick),
    .alarm_switch(alarm_switch)
);
`default_nettype wire

// File: test/sound_gen_clock_prescaler_tb.sv
// self-checking bench for the sound generator clock block.
// assumes the checker file is compiled beside it; oscillators are fast stand-ins.
`timescale 1ns/1ns
`default_nettype none
module sound_gen_clock_prescaler_tb;
    import sound_gen_pkg::*;
    localparam int LOW_HALF  = 4; // low oscillator half period in clk cycles
    localparam int HIGH_HALF = 2; // high oscillator half period in clk cycles
    localparam int BASE_GAP  = 2 * LOW_HALF;
    logic        clk, nrst, psel, penable, pwrite, low_src, high_src;
    logic        base_tick, ch1, ch2, alarm, pready, pslverr, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb;
    logic [1:0]  work;
    int          num_errors, compares, osc_cnt, n, ps;

    sound_gen_clock_prescaler uut (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_source(low_src), .high_speed_source(high_src),
        .base_clock_tick(base_tick), .tone_working_clock(work), .chan1_out(ch1),
        .chan2_out(ch2), .alarm_switch(alarm)
    );
    // ----------------------------------------
    // clock and oscillator stand-ins
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 1;
        if (osc_cnt % LOW_HALF == LOW_HALF - 1) low_src <= ~low_src;
        if (osc_cnt % HIGH_HALF == HIGH_HALF - 1) high_src <= ~high_src;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [11:0] ba(input logic [IDX_W-1:0] idx);
        return {idx, 2'b00};
    endfunction
    function automatic logic sig(input int w);
        case (w)
            0: return base_tick;
            1: return work[0];
            2: return work[1];
            3: return ch1;
            default: return ch2;
        endcase
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv     = prdata;
        errv    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d, 4'h1);
    endtask
    // cycles between two events: strobe high, or level change for the sound outputs
    task automatic gap(input int w, output int res);
        int  k;
        int  first;
        logic p;
        res   = -1;
        first = -1;
        p     = sig(w);
        for (k = 0; k < 4000 && res < 0; k++) begin
            @(posedge clk);
            #1;
            if (w < 3 ? sig(w) === 1'b1 : sig(w) !== p) begin
                if (first < 0) first = k;
                else res = k - first;
            end
            p = sig(w);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, low_src, high_src} = 6'b0;
        {paddr, pwdata, pstrb, num_errors, compares, osc_cnt} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check("outputs after reset", {alarm, ch1, ch2}, 0);
        apb_xfer(1'b0, ba(IDX_PRESCALER), 0, 4'h0);
        check("write-only read data", rdv, 0);
        check("write-only read error", errv, 0);
        apb_xfer(1'b0, 12'h000, 0, 4'h0);
        check("unmapped read error", errv, 1);
        apb_xfer(1'b1, ba(IDX_STATUS), 32'h0000_000F, 4'h1);
        check("status write error", errv, 1);
        wr(ba(IDX_CLK_SEL), 32'h0000_0002);
        #1;
        check("alarm on", alarm, 1);
        apb_xfer(1'b1, ba(IDX_CLK_SEL), 0, 4'h0);
        #1;
        check("alarm kept, strobe off", alarm, 1);
        wr(ba(IDX_CLK_SEL), 0);
        #1;
        check("alarm off", alarm, 0);
        gap(0, n);
        check("low source base gap", n, BASE_GAP);
        wr(ba(IDX_CLK_SEL), 32'h0000_0001);
        gap(0, n);
        check("fast rc base gap", n, DIV_FAST * 2 * HIGH_HALF);
        apb_xfer(1'b0, ba(IDX_STATUS), 0, 4'h0);
        check("status source bit", rdv & 32'h0000_0008, 32'h0000_0008);
        wr(ba(IDX_CLK_SEL), 32'h0000_0005);
        gap(0, n);
        check("slow rc base gap", n, DIV_SLOW * 2 * HIGH_HALF);
        wr(ba(IDX_CLK_SEL), 0);
        for (ps = 0; ps < 4; ps++) begin
            wr(ba(IDX_PRESCALER), ps | ((3 - ps) << 2));
            gap(1, n);
            check("channel one working gap", n, BASE_GAP << ps);
            gap(2, n);
            check("channel two working gap", n, BASE_GAP << (3 - ps));
        end
        wr(ba(IDX_PRESCALER), 0);
        wr(ba(IDX_CH1_LOW), 0);
        wr(ba(IDX_CH1_HIGH), 32'h0000_0002);
        gap(3, n);
        check("channel one seed 20h", n, 122 * BASE_GAP);
        wr(ba(IDX_CH2_NIB3), 32'h0000_0001);
        wr(ba(IDX_CH2_NIB4), 0);
        gap(4, n);
        check("channel two seed 01h", n, 127 * BASE_GAP);
        wr(ba(IDX_PRESCALER), 32'h0000_0003);
        wr(ba(IDX_CH1_LOW), 32'h0000_0005);
        wr(ba(IDX_CH1_HIGH), 32'h0000_0001);
        gap(3, n);
        check("channel one seed 15h at /8", n, 15 * (BASE_GAP << 3));
        wr(ba(IDX_PRESCALER), 0);
        wr(ba(IDX_CH1_LOW), 0);
        wr(ba(IDX_CH1_HIGH), 32'h0000_000A);
        gap(3, n);
        check("noise output moves", n > 0 && n < 122 * BASE_GAP, 1);
        wr(ba(IDX_CH2_NIB4), 32'h0000_0008);
        gap(4, n);
        check("channel two noise moves", n > 0 && n < 127 * BASE_GAP, 1);
        wr(ba(IDX_CLK_SEL), 32'h0000_0002);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        check("alarm after second reset", alarm, 0);
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
